// file: design/miw_pkg.sv
// Shared constants, types and register map of the interrupt and power wake block
package miw_pkg;

  // Clock and timing
  localparam int CLK_FREQ_MHZ = 200;
  localparam int WAKE_TIME_US = 16000;
  localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_FREQ_MHZ;
  localparam int GUARD_MCYCLES = 2;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [3:0] ADDR_IE = 4'h0;
  localparam logic [3:0] ADDR_FLAGS = 4'h1;
  localparam logic [3:0] ADDR_CTRL = 4'h2;
  localparam logic [3:0] ADDR_STATUS = 4'h3;

  // Enable register fields, also the vector numbering
  localparam int IE_EXT0 = 0;
  localparam int IE_TMR0 = 1;
  localparam int IE_EXT1 = 2;
  localparam int IE_TMR1 = 3;
  localparam int IE_SER = 4;
  localparam int IE_TMR2 = 5;
  localparam int IE_GLOBAL = 7;
  localparam int NUM_VECTORS = 6;
  localparam logic [7:0] IE_RESET = 8'h00;
  localparam logic [7:0] IE_WMASK = 8'hbf;

  // Flag register fields
  localparam int FLG_EXT0 = 0;
  localparam int FLG_EXT1 = 1;
  localparam int FLG_TMR0 = 2;
  localparam int FLG_TMR1 = 3;
  localparam int FLG_TMR2_OVF = 4;
  localparam int FLG_TMR2_EXT = 5;
  localparam int FLG_SPI = 6;
  localparam int NUM_FLAGS = 7;

  // Control register fields
  localparam int CTRL_EXT0_EDGE = 0;
  localparam int CTRL_EXT1_EDGE = 1;
  localparam int CTRL_SPI_IE = 2;
  localparam int CTRL_IDLE = 3;
  localparam int CTRL_PDOWN = 4;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Status register fields
  localparam int STAT_IDLE = 6;
  localparam int STAT_PDOWN = 7;

  // Peripheral event pulses
  typedef struct packed {
    logic tmr0_ovf;
    logic tmr1_ovf;
    logic tmr2_ovf;
    logic tmr2_ext_edge;
    logic spi_done;
  } miw_evt_s;

  // Timer 2 operating mode levels
  typedef struct packed {
    logic updown;
    logic baud;
  } miw_t2mode_s;

  // UART flag levels
  typedef struct packed {
    logic rx_flag;
    logic tx_flag;
  } miw_uart_s;

  typedef enum logic [2:0] {
    MIW_RUN,
    MIW_IDLE,
    MIW_PDOWN,
    MIW_RESTART,
    MIW_GUARD
  } miw_pwr_e;

endpackage

// file: design/miw_flag.sv
// One sticky event flag with set, clear and toggle
`timescale 1ns/10ps
`default_nettype none
module miw_flag (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_set,
  input wire logic i_clr,
  input wire logic i_toggle,
  output logic o_flag
);

  // Set beats clear so an event in the clearing cycle survives
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_toggle) begin
      o_flag <= ~o_flag;
    end else if (i_clr) begin
      o_flag <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: design/miw_irq_wake.sv
// Interrupt enable, request gating and idle/power-down wake control
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module miw_irq_wake #(
  parameter int WAKE_CYCLES = miw_pkg::WAKE_CYCLES,
  parameter int GUARD_MCYCLES = miw_pkg::GUARD_MCYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [miw_pkg::ADDR_W-1:0] i_addr,
  input wire logic [miw_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [miw_pkg::DATA_W-1:0] o_rdata,
  input wire logic [1:0] i_ext_irq_pin_n,
  input wire miw_pkg::miw_evt_s i_evt,
  input wire miw_pkg::miw_t2mode_s i_t2_mode,
  input wire miw_pkg::miw_uart_s i_uart,
  input wire logic i_spi_slave,
  input wire logic i_mcycle_start,
  input wire logic [miw_pkg::NUM_VECTORS-1:0] i_vector_ack,
  input wire logic i_reset_pin,
  input wire logic i_ext_prog_mem,
  input wire logic i_ale,
  input wire logic i_program_store_strobe,
  input wire logic [7:0] i_port2_addr,
  input wire logic [7:0] i_port2_data,
  output logic [miw_pkg::NUM_VECTORS-1:0] o_irq_req,
  output logic o_irq_pending,
  output logic o_core_halt,
  output logic o_osc_stop,
  output logic o_ram_wr_inhibit,
  output logic o_core_reset,
  output logic o_ale,
  output logic o_program_store_strobe,
  output logic o_port0_float,
  output logic [7:0] o_port2
);

  localparam int CNT_W = $clog2(WAKE_CYCLES + 1);
  localparam logic [CNT_W-1:0] WAKE_LOAD = CNT_W'(WAKE_CYCLES - 1);
  localparam logic [1:0] GUARD_LOAD = 2'(GUARD_MCYCLES - 1);

  logic [7:0] interrupt_enable_mask;
  logic ext0_edge_mode;
  logic ext1_edge_mode;
  logic spi_irq_enable;
  logic [1:0] ext_pin_prev_n;
  logic [1:0] polled_tmr;
  logic [miw_pkg::NUM_FLAGS-1:0] flags;
  logic [miw_pkg::NUM_FLAGS-1:0] flag_set;
  logic [miw_pkg::NUM_FLAGS-1:0] flag_clr;
  logic [miw_pkg::NUM_FLAGS-1:0] flag_tog;
  logic [miw_pkg::NUM_VECTORS-1:0] src;
  logic [miw_pkg::NUM_VECTORS-1:0] wake_src;
  logic [miw_pkg::NUM_VECTORS-1:0] req;
  logic [CNT_W-1:0] wake_cnt;
  logic [1:0] guard_cnt;
  logic [1:0] ext_fall;
  logic global_irq_enable;
  logic spi_src;
  logic uart_src;
  logic timer2_req;
  logic idle_wake;
  logic pdown_wake;
  logic wr_ie;
  logic wr_flags;
  logic wr_ctrl;
  logic enter_idle;
  logic enter_pdown;
  logic in_idle_pins;
  logic in_pdown_pins;
  miw_pkg::miw_pwr_e pwr_state;
  miw_pkg::miw_pwr_e next_pwr_state;

  assign wr_ie = i_wr && (i_addr == miw_pkg::ADDR_IE);
  assign wr_flags = i_wr && (i_addr == miw_pkg::ADDR_FLAGS);
  assign wr_ctrl = i_wr && (i_addr == miw_pkg::ADDR_CTRL);
  assign global_irq_enable = interrupt_enable_mask[miw_pkg::IE_GLOBAL];

  // Unimplemented bit 6 is never stored, so a stray one reads back as zero
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      interrupt_enable_mask <= miw_pkg::IE_RESET;
    end else if (wr_ie) begin
      interrupt_enable_mask <= i_wdata & miw_pkg::IE_WMASK;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      {spi_irq_enable, ext1_edge_mode, ext0_edge_mode} <= miw_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ext0_edge_mode <= i_wdata[miw_pkg::CTRL_EXT0_EDGE];
      ext1_edge_mode <= i_wdata[miw_pkg::CTRL_EXT1_EDGE];
      spi_irq_enable <= i_wdata[miw_pkg::CTRL_SPI_IE];
    end
  end

  // External pin falling edges for edge-triggered mode
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ext_pin_prev_n <= 2'h3;
    end else begin
      ext_pin_prev_n <= i_ext_irq_pin_n;
    end
  end

  assign ext_fall = ext_pin_prev_n & ~i_ext_irq_pin_n;

  // Flag set, clear and toggle terms
  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_tog = '0;
    flag_set[miw_pkg::FLG_EXT0] = ext_fall[0] && ext0_edge_mode;
    flag_set[miw_pkg::FLG_EXT1] = ext_fall[1] && ext1_edge_mode;
    flag_set[miw_pkg::FLG_TMR0] = i_evt.tmr0_ovf;
    flag_set[miw_pkg::FLG_TMR1] = i_evt.tmr1_ovf;
    flag_set[miw_pkg::FLG_TMR2_OVF] = i_evt.tmr2_ovf && !i_t2_mode.baud;
    flag_set[miw_pkg::FLG_TMR2_EXT] = i_evt.tmr2_ext_edge && !i_t2_mode.updown;
    flag_tog[miw_pkg::FLG_TMR2_EXT] = i_evt.tmr2_ovf && i_t2_mode.updown;
    flag_set[miw_pkg::FLG_SPI] = i_evt.spi_done;
    if (wr_flags) begin
      flag_clr = i_wdata[miw_pkg::NUM_FLAGS-1:0];
    end
    // Hardware clears only the timer 0/1 and edge flags on vectoring
    flag_clr[miw_pkg::FLG_EXT0] = flag_clr[miw_pkg::FLG_EXT0] || i_vector_ack[miw_pkg::IE_EXT0];
    flag_clr[miw_pkg::FLG_EXT1] = flag_clr[miw_pkg::FLG_EXT1] || i_vector_ack[miw_pkg::IE_EXT1];
    flag_clr[miw_pkg::FLG_TMR0] = flag_clr[miw_pkg::FLG_TMR0] || i_vector_ack[miw_pkg::IE_TMR0];
    flag_clr[miw_pkg::FLG_TMR1] = flag_clr[miw_pkg::FLG_TMR1] || i_vector_ack[miw_pkg::IE_TMR1];
    // Timer 2 flags are left for software to clear
  end

  genvar gi;
  generate
    for (gi = 0; gi < miw_pkg::NUM_FLAGS; gi++) begin : g_flag
      miw_flag u_flag (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_set(flag_set[gi]),
        .i_clr(flag_clr[gi]),
        .i_toggle(flag_tog[gi]),
        .o_flag(flags[gi])
      );
    end
  endgenerate

  // Timer 0/1 flags reach the request only at the next machine cycle start
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      polled_tmr <= 2'h0;
    end else if (i_mcycle_start) begin
      polled_tmr <= {flags[miw_pkg::FLG_TMR1], flags[miw_pkg::FLG_TMR0]};
    end else begin
      polled_tmr <= polled_tmr & {flags[miw_pkg::FLG_TMR1], flags[miw_pkg::FLG_TMR0]};
    end
  end

  // Request sources, one per vector
  assign spi_src = flags[miw_pkg::FLG_SPI] && spi_irq_enable;
  assign uart_src = i_uart.rx_flag || i_uart.tx_flag;
  // In up/down mode the external flag is a count bit, not a request
  assign timer2_req = flags[miw_pkg::FLG_TMR2_OVF] ||
                      (flags[miw_pkg::FLG_TMR2_EXT] && !i_t2_mode.updown);

  always_comb begin
    src = '0;
    src[miw_pkg::IE_EXT0] = ext0_edge_mode ? flags[miw_pkg::FLG_EXT0] : !i_ext_irq_pin_n[0];
    src[miw_pkg::IE_EXT1] = ext1_edge_mode ? flags[miw_pkg::FLG_EXT1] : !i_ext_irq_pin_n[1];
    src[miw_pkg::IE_TMR0] = polled_tmr[0];
    src[miw_pkg::IE_TMR1] = polled_tmr[1];
    src[miw_pkg::IE_SER] = uart_src || spi_src;
    src[miw_pkg::IE_TMR2] = timer2_req;
    wake_src = src;
    // A master SPI transfer cannot wake an idle core
    wake_src[miw_pkg::IE_SER] = uart_src || (spi_src && i_spi_slave);
  end

  assign req = global_irq_enable ?
               (src & interrupt_enable_mask[miw_pkg::NUM_VECTORS-1:0]) : '0;
  assign o_irq_req = req;
  assign o_irq_pending = |req;

  assign idle_wake = global_irq_enable &&
                     |(wake_src & interrupt_enable_mask[miw_pkg::NUM_VECTORS-1:0]);
  // Clock is stopped in power-down, so only a held low level can wake it
  assign pdown_wake = global_irq_enable &&
                      ((interrupt_enable_mask[miw_pkg::IE_EXT0] && !ext0_edge_mode &&
                        !i_ext_irq_pin_n[0]) ||
                       (interrupt_enable_mask[miw_pkg::IE_EXT1] && !ext1_edge_mode &&
                        !i_ext_irq_pin_n[1]));

  assign enter_idle = wr_ctrl && i_wdata[miw_pkg::CTRL_IDLE];
  assign enter_pdown = wr_ctrl && i_wdata[miw_pkg::CTRL_PDOWN];

  always_comb begin
    next_pwr_state = pwr_state;
    case (pwr_state)
      miw_pkg::MIW_RUN: begin
        if (enter_pdown) begin
          next_pwr_state = miw_pkg::MIW_PDOWN;
        end else if (enter_idle) begin
          next_pwr_state = miw_pkg::MIW_IDLE;
        end
      end
      miw_pkg::MIW_IDLE: begin
        if (i_reset_pin) begin
          next_pwr_state = miw_pkg::MIW_GUARD;
        end else if (idle_wake) begin
          next_pwr_state = miw_pkg::MIW_RUN;
        end
      end
      miw_pkg::MIW_PDOWN: begin
        if (i_reset_pin) begin
          next_pwr_state = miw_pkg::MIW_RUN;
        end else if (pdown_wake) begin
          next_pwr_state = miw_pkg::MIW_RESTART;
        end
      end
      miw_pkg::MIW_RESTART: begin
        if (i_reset_pin) begin
          next_pwr_state = miw_pkg::MIW_RUN;
        end else if (wake_cnt == '0) begin
          next_pwr_state = miw_pkg::MIW_RUN;
        end
      end
      miw_pkg::MIW_GUARD: begin
        if (i_mcycle_start && guard_cnt == 2'h0) begin
          next_pwr_state = miw_pkg::MIW_RUN;
        end
      end
      default: begin
        next_pwr_state = miw_pkg::MIW_RUN;
      end
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pwr_state <= miw_pkg::MIW_RUN;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  // Oscillator restart delay before the service routine may start
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wake_cnt <= '0;
    end else if (pwr_state == miw_pkg::MIW_PDOWN) begin
      wake_cnt <= WAKE_LOAD;
    end else if (pwr_state == miw_pkg::MIW_RESTART && wake_cnt != '0) begin
      wake_cnt <= wake_cnt - CNT_W'(1);
    end
  end

  // Machine cycles the core may still run after a reset ends idle
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      guard_cnt <= 2'h0;
    end else if (pwr_state != miw_pkg::MIW_GUARD) begin
      guard_cnt <= GUARD_LOAD;
    end else if (i_mcycle_start && guard_cnt != 2'h0) begin
      guard_cnt <= guard_cnt - 2'h1;
    end
  end

  // Core reset follows the guard window, or immediately out of power-down
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_core_reset <= 1'b0;
    end else begin
      o_core_reset <= (pwr_state == miw_pkg::MIW_GUARD && next_pwr_state == miw_pkg::MIW_RUN) ||
                      ((pwr_state == miw_pkg::MIW_PDOWN || pwr_state == miw_pkg::MIW_RESTART) &&
                       i_reset_pin);
    end
  end

  assign in_idle_pins = (pwr_state == miw_pkg::MIW_IDLE);
  assign in_pdown_pins = (pwr_state == miw_pkg::MIW_PDOWN) ||
                         (pwr_state == miw_pkg::MIW_RESTART);

  // Core halted in both modes, peripherals keep running in idle
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_core_halt <= 1'b0;
      o_osc_stop <= 1'b0;
      o_ram_wr_inhibit <= 1'b0;
    end else begin
      o_core_halt <= (next_pwr_state == miw_pkg::MIW_IDLE) || (next_pwr_state == miw_pkg::MIW_PDOWN) ||
                     (next_pwr_state == miw_pkg::MIW_RESTART);
      o_osc_stop <= (next_pwr_state == miw_pkg::MIW_PDOWN);
      // Port writes stay allowed in the guard window; only RAM is protected
      o_ram_wr_inhibit <= (next_pwr_state == miw_pkg::MIW_GUARD) ||
                          (next_pwr_state == miw_pkg::MIW_PDOWN) ||
                          (next_pwr_state == miw_pkg::MIW_RESTART);
    end
  end

  // Pin states in the low-power modes
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_ale <= 1'b1;
      o_program_store_strobe <= 1'b1;
      o_port0_float <= 1'b0;
      o_port2 <= 8'h00;
    end else begin
      o_ale <= in_idle_pins ? 1'b1 : (in_pdown_pins ? 1'b0 : i_ale);
      o_program_store_strobe <= in_idle_pins ? 1'b1 : (in_pdown_pins ? 1'b0 : i_program_store_strobe);
      o_port0_float <= i_ext_prog_mem && (in_idle_pins || in_pdown_pins);
      if (i_ext_prog_mem && in_idle_pins) begin
        o_port2 <= i_port2_addr;
      end else if (in_pdown_pins) begin
        o_port2 <= i_port2_data;
      end else begin
        o_port2 <= i_ext_prog_mem ? i_port2_addr : i_port2_data;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        miw_pkg::ADDR_IE: o_rdata <= interrupt_enable_mask;
        miw_pkg::ADDR_FLAGS: o_rdata <= {1'b0, flags};
        miw_pkg::ADDR_CTRL: begin
          o_rdata <= 8'h00;
          o_rdata[miw_pkg::CTRL_EXT0_EDGE] <= ext0_edge_mode;
          o_rdata[miw_pkg::CTRL_EXT1_EDGE] <= ext1_edge_mode;
          o_rdata[miw_pkg::CTRL_SPI_IE] <= spi_irq_enable;
          o_rdata[miw_pkg::CTRL_IDLE] <= in_idle_pins;
          o_rdata[miw_pkg::CTRL_PDOWN] <= in_pdown_pins;
        end
        miw_pkg::ADDR_STATUS: begin
          o_rdata <= {in_pdown_pins, in_idle_pins, req};
        end
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// file: testbench/miw_irq_wake_checker.sv
// Port checker for the interrupt and power wake block
`timescale 1ns/10ps
`default_nettype none
module miw_irq_wake_checker (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic [miw_pkg::ADDR_W-1:0] i_addr,
  input wire logic [miw_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [miw_pkg::DATA_W-1:0] o_rdata,
  input wire miw_pkg::miw_evt_s i_evt,
  input wire miw_pkg::miw_t2mode_s i_t2_mode,
  input wire logic i_spi_slave,
  input wire logic i_mcycle_start,
  input wire logic i_reset_pin,
  input wire logic [miw_pkg::NUM_VECTORS-1:0] o_irq_req,
  input wire logic o_irq_pending,
  input wire logic o_core_halt,
  input wire logic o_osc_stop,
  input wire logic o_ram_wr_inhibit,
  input wire logic o_core_reset,
  input wire logic o_ale,
  input wire logic o_program_store_strobe
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] ie_q;
  logic idle_pins;
  // Shadow of the enable register, so masking can be judged from ports alone
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      ie_q <= miw_pkg::IE_RESET;
    end else if (i_wr && i_addr == miw_pkg::ADDR_IE) begin
      ie_q <= i_wdata & miw_pkg::IE_WMASK;
    end
  end
  // Idle is the only halted state with both strobes high
  assign idle_pins = o_core_halt && o_ale && o_program_store_strobe;
  sequence idle_entry_s;
    i_wr && i_addr == miw_pkg::ADDR_CTRL && i_wdata[miw_pkg::CTRL_IDLE]
      && !i_wdata[miw_pkg::CTRL_PDOWN] && !o_core_halt
      && !o_irq_pending;
  endsequence
  sequence idle_pins_s;
    o_core_halt ##1 (o_ale && o_program_store_strobe);
  endsequence
  pending_or_a: assert property (o_irq_pending == |o_irq_req)
    else $error("pending differs from request OR");
  source_mask_a: assert property ((o_irq_req & ~ie_q[5:0]) == '0)
    else $error("request on a masked source");
  global_gate_a: assert property (!ie_q[7] |-> o_irq_req == '0)
    else $error("request with global enable clear");
  ie_read_a: assert property (i_rd && i_addr == miw_pkg::ADDR_IE |=> o_rdata == $past(ie_q))
    else $error("enable register readback wrong");
  t2_same_a: assert property (i_evt.tmr2_ovf && !i_t2_mode.baud && ie_q[7] && ie_q[5] && !i_wr
    |=> o_irq_req[5])
    else $error("timer 2 request late");
  t0_late_a: assert property (i_evt.tmr0_ovf && !o_irq_req[1] && !i_mcycle_start && !i_wr
    |=> !o_irq_req[1])
    else $error("timer 0 request before machine cycle poll");
  idle_strobes_a: assert property (idle_entry_s |=> idle_pins_s)
    else $error("idle strobes not high");
  pdown_stop_a: assert property (i_wr && i_addr == miw_pkg::ADDR_CTRL && i_wdata[miw_pkg::CTRL_PDOWN]
    && !o_core_halt |=> o_osc_stop && o_core_halt)
    else $error("power-down entry failed");
  pdown_pins_a: assert property (o_osc_stop && $past(o_osc_stop)
    |-> !o_ale && !o_program_store_strobe)
    else $error("power-down strobes not low");
  idle_wake_a: assert property (idle_pins && o_irq_pending && i_spi_slave |=> !o_core_halt)
    else $error("idle not left on request");
  guard_inhibit_a: assert property (idle_pins && i_reset_pin |=> o_ram_wr_inhibit)
    else $error("ram writes not blocked after idle reset");
  reset_pulse_a: assert property (o_core_reset |=> !o_core_reset)
    else $error("core reset longer than one cycle");
endmodule
bind miw_irq_wake miw_irq_wake_checker miw_irq_wake_checker_i (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_evt(i_evt), .i_t2_mode(i_t2_mode),
  .i_spi_slave(i_spi_slave), .i_mcycle_start(i_mcycle_start), .i_reset_pin(i_reset_pin),
  .o_irq_req(o_irq_req), .o_irq_pending(o_irq_pending), .o_core_halt(o_core_halt),
  .o_osc_stop(o_osc_stop), .o_ram_wr_inhibit(o_ram_wr_inhibit), .o_core_reset(o_core_reset),
  .o_ale(o_ale), .o_program_store_strobe(o_program_store_strobe));
`default_nettype wire

// file: testbench/miw_core_model.sv
// Core-side model: machine-cycle marker and vector acknowledge
`timescale 1ns/10ps
`default_nettype none
module miw_core_model (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_ack_en,
  input wire logic [5:0] i_irq_req,
  input wire logic i_core_halt,
  output logic o_mcycle_start,
  output logic [5:0] o_vector_ack
);
  logic [2:0] phase;
  // Six states to a machine cycle, start marked once
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      phase <= 3'h0;
      o_mcycle_start <= 1'b0;
    end else begin
      phase <= (phase == 3'h5) ? 3'h0 : phase + 3'h1;
      o_mcycle_start <= (phase == 3'h5);
    end
  end
  // Lowest pending vector only, and never while halted
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_vector_ack <= 6'h00;
    end else if (i_ack_en && !i_core_halt && o_mcycle_start) begin
      o_vector_ack <= i_irq_req & (~i_irq_req + 6'h01);
    end else begin
      o_vector_ack <= 6'h00;
    end
  end
endmodule
`default_nettype wire

// file: testbench/miw_irq_wake_tb.sv
// Self-checking bench of the interrupt and power wake block
`timescale 1ns/10ps
`default_nettype none
module miw_irq_wake_tb;
  localparam int WAKE = 20;
  logic clk, rst_n, wr, rd, ack_en, spi_slave, rst_pin, ext_prog, mcyc;
  logic pend, halt, oscs, inh, crst, ale, pss, p0f;
  logic [1:0] pin_n;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, port2;
  logic [5:0] ack, req;
  miw_pkg::miw_evt_s evt;
  miw_pkg::miw_t2mode_s t2m;
  miw_pkg::miw_uart_s uart;
  int err_total, checks;
  miw_irq_wake #(.WAKE_CYCLES(WAKE), .GUARD_MCYCLES(2)) miw_irq_wake_i (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_ext_irq_pin_n(pin_n), .i_evt(evt), .i_t2_mode(t2m),
    .i_uart(uart), .i_spi_slave(spi_slave), .i_mcycle_start(mcyc), .i_vector_ack(ack),
    .i_reset_pin(rst_pin), .i_ext_prog_mem(ext_prog), .i_ale(1'b0), .i_program_store_strobe(1'b0),
    .i_port2_addr(8'h5a), .i_port2_data(8'ha5), .o_irq_req(req), .o_irq_pending(pend),
    .o_core_halt(halt), .o_osc_stop(oscs), .o_ram_wr_inhibit(inh), .o_core_reset(crst),
    .o_ale(ale), .o_program_store_strobe(pss), .o_port0_float(p0f), .o_port2(port2));
  miw_core_model miw_core_model_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_ack_en(ack_en),
    .i_irq_req(req), .i_core_halt(halt), .o_mcycle_start(mcyc), .o_vector_ack(ack));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic bus_rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp, what);
  endtask
  task automatic pulse(input miw_pkg::miw_evt_s e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    #1;
  endtask
  function automatic logic probe(input int sel);
    case (sel)
      0: return halt;
      1: return req[1];
      2: return crst;
      default: return oscs;
    endcase
  endfunction
  // Bounded wait, n counts the cycles spent
  task automatic wait_for(input int sel, input logic want, input int lim, output int n);
    n = 0;
    while (probe(sel) !== want) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        err_total++;
        $display("BAD %0t wait ran out", $time);
        summarize();
      end
    end
  endtask
  task automatic t_regs();
    bus_rd(miw_pkg::ADDR_IE, miw_pkg::IE_RESET, "ie reset");
    bus_wr(miw_pkg::ADDR_IE, 8'hbf);
    bus_rd(miw_pkg::ADDR_IE, 8'hbf, "ie readback");
    bus_rd(4'hf, 8'h00, "unmapped read");
  endtask
  task automatic t_ext();
    bus_wr(miw_pkg::ADDR_IE, 8'h05);
    @(posedge clk);
    pin_n <= 2'b00;
    @(posedge clk);
    #1;
    chk({2'b00, req}, 8'h00, "global enable off");
    bus_wr(miw_pkg::ADDR_IE, 8'h81);
    chk({2'b00, req}, 8'h01, "ext0 alone");
    bus_wr(miw_pkg::ADDR_IE, 8'h84);
    chk({2'b00, req}, 8'h04, "ext1 alone");
    @(posedge clk);
    pin_n <= 2'b11;
  endtask
  task automatic t_tmr2();
    bus_wr(miw_pkg::ADDR_IE, 8'ha0);
    pulse(5'h04);
    chk({2'b00, req}, 8'h20, "overflow request");
    @(posedge clk);
    ack_en <= 1'b1;
    repeat (13) @(posedge clk);
    ack_en <= 1'b0;
    bus_rd(miw_pkg::ADDR_FLAGS, 8'h10, "flag kept after vectoring");
    bus_wr(miw_pkg::ADDR_FLAGS, 8'h10);
    pulse(5'h02);
    chk({2'b00, req}, 8'h20, "external edge request");
    bus_wr(miw_pkg::ADDR_FLAGS, 8'h20);
    t2m <= 2'b10;
    pulse(5'h04);
    bus_rd(miw_pkg::ADDR_FLAGS, 8'h30, "up/down toggles flag");
    bus_wr(miw_pkg::ADDR_FLAGS, 8'h10);
    chk({2'b00, req}, 8'h00, "toggled flag silent");
    bus_wr(miw_pkg::ADDR_FLAGS, 8'h20);
    t2m <= 2'b01;
    pulse(5'h04);
    chk({2'b00, req}, 8'h00, "baud rollover silent");
    t2m <= 2'b00;
  endtask
  task automatic t_tmr0();
    int n;
    bus_wr(miw_pkg::ADDR_IE, 8'h82);
    pulse(5'h10);
    chk({2'b00, req}, 8'h00, "not polled yet");
    wait_for(1, 1'b1, 8, n);
    ack_en <= 1'b1;
    wait_for(1, 1'b0, 8, n);
    ack_en <= 1'b0;
  endtask
  task automatic t_serial();
    bus_wr(miw_pkg::ADDR_IE, 8'h90);
    pulse(5'h01);
    chk({2'b00, req}, 8'h00, "spi enable clear");
    bus_wr(miw_pkg::ADDR_CTRL, 8'h04);
    chk({2'b00, req}, 8'h10, "spi request");
    bus_wr(miw_pkg::ADDR_FLAGS, 8'h40);
    uart <= 2'b10;
    bus_wr(miw_pkg::ADDR_IE, 8'h90);
    chk({2'b00, req}, 8'h10, "uart request");
    bus_wr(miw_pkg::ADDR_IE, 8'h80);
    chk({2'b00, req}, 8'h00, "serial masked");
    uart <= 2'b00;
  endtask
  task automatic t_idle();
    int n;
    ext_prog <= 1'b1;
    bus_wr(miw_pkg::ADDR_IE, 8'h90);
    bus_wr(miw_pkg::ADDR_CTRL, 8'h0c);
    chk({7'h00, halt}, 8'h01, "idle halts");
    repeat (2) @(posedge clk);
    #1;
    chk({5'h00, ale, pss, p0f}, 8'h07, "idle pins");
    chk(port2, 8'h5a, "idle port 2");
    pulse(5'h01);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, halt}, 8'h01, "master keeps idle");
    bus_wr(miw_pkg::ADDR_FLAGS, 8'h40);
    spi_slave <= 1'b1;
    pulse(5'h01);
    wait_for(0, 1'b0, 3, n);
    bus_wr(miw_pkg::ADDR_FLAGS, 8'h40);
  endtask
  task automatic t_pdown();
    int n;
    bus_wr(miw_pkg::ADDR_IE, 8'h81);
    bus_wr(miw_pkg::ADDR_CTRL, 8'h10);
    chk({6'h00, oscs, halt}, 8'h03, "power-down entry");
    repeat (2) @(posedge clk);
    #1;
    chk({5'h00, ale, pss, p0f}, 8'h01, "power-down pins");
    chk(port2, 8'ha5, "power-down port 2");
    pin_n <= 2'b10;
    wait_for(3, 1'b0, 3, n);
    wait_for(0, 1'b0, WAKE + 4, n);
    chk(8'(n >= WAKE - 3 && n <= WAKE + 3), 8'h01, "restart delay");
    pin_n <= 2'b11;
  endtask
  task automatic t_reset_wake();
    int n;
    bus_wr(miw_pkg::ADDR_CTRL, 8'h10);
    rst_pin <= 1'b1;
    @(posedge clk);
    rst_pin <= 1'b0;
    // One-cycle pulse, look once it has settled
    #1;
    wait_for(2, 1'b1, 3, n);
    chk({7'h00, oscs}, 8'h00, "oscillator back");
    bus_wr(miw_pkg::ADDR_CTRL, 8'h08);
    // Let the idle strobes rise before the reset pin
    @(posedge clk);
    rst_pin <= 1'b1;
    @(posedge clk);
    rst_pin <= 1'b0;
    @(posedge clk);
    #1;
    chk({7'h00, inh}, 8'h01, "ram blocked");
    wait_for(2, 1'b1, 14, n);
    @(posedge clk);
    #1;
    chk({6'h00, inh, halt}, 8'h00, "guard over");
  endtask
  initial begin
    {rst_n, wr, rd, ack_en, spi_slave, rst_pin, ext_prog} = '0;
    {pin_n, addr, wdata, evt, t2m, uart} = '0;
    pin_n = 2'b11;
    err_total = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_ext();
    t_tmr2();
    t_tmr0();
    t_serial();
    t_idle();
    t_pdown();
    t_reset_wake();
    summarize();
  end
endmodule
`default_nettype wire
